// [bench/cms_bus_model.sv]
`timescale 1ns/1ns
module cms_bus_model (
  // core side
  input wire logic i_clk,
  input wire logic i_cmd,
  input wire logic i_beat,
  // bus side
  output logic o_bus_clk,
  output logic [4:0] o_beats
);
  // bus clock runs free, phase offset from the core clock on purpose
  initial begin
    o_bus_clk = 1'b0;
    o_beats = 5'h00;
    #5;
    forever #32 o_bus_clk = ~o_bus_clk;
  end
  // beats per transfer, restarted by each command
  always @(posedge i_clk) begin
    o_beats <= i_cmd ? {4'h0, i_beat} : o_beats + {4'h0, i_beat};
  end
endmodule : cms_bus_model

// [bench/cms_top_bench.sv]
`timescale 1ns/1ns
module cms_top_bench;
  logic i_mclk, i_rstn, i_ld_alloc, i_ld_dealloc, i_ld_issue, i_ld_spec, i_ld_fault;
  logic i_br_resolved, i_br_mispredict, i_st_alloc, i_st_exec, i_st_uc, i_st_retire;
  logic i_st_wr_ready, i_acc_valid, i_acc_sw_pf, i_acc_nt, i_acc_fp, i_miss_done;
  logic i_evict_valid, i_bus_clk, o_ld_full, o_fwd_hit, o_page_fault, o_st_full;
  logic o_st_wr_valid, o_acc_ready, o_evict_ready, o_bus_cmd, o_bus_wr, o_bus_uc;
  logic o_bus_beat, o_bus_busy, o_init_done;
  logic [31:0] i_ld_addr, i_st_addr, i_acc_addr, i_evict_addr, o_st_wr_addr, o_bus_addr;
  logic [3:0] i_ld_size, i_st_size, i_acc_set, o_miss_cnt;
  logic [4:0] o_fwd_idx, o_st_tail, i_st_idx, o_acc_lat, o_bus_beats, n_beats;
  logic [2:0] i_hit_lvl, i_hit_way, o_bus_fill;
  logic [2:0][2:0] o_victim;
  logic [31:0] sq [24];
  logic [31:0] po [4] = '{32'hf00, 32'h0, 32'hd00, 32'h180};
  logic [31:0] ps [4] = '{32'h80, 32'h180, 32'h80, 32'hffff_ff80};
  logic [31:0] pg, a;
  int n_fail, total_checks, cyc;
  cms_top i_dut (.*);
  cms_bus_model i_bm (.i_clk(i_mclk), .i_cmd(o_bus_cmd), .i_beat(o_bus_beat),
    .o_bus_clk(i_bus_clk), .o_beats(n_beats));
  initial begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_fail++;
      close_out;
    end
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  function automatic logic [4:0] exp_lat(input logic [2:0] l, input logic f);
    if (l[0]) return f ? 5'h09 : 5'h02;
    if (l[1]) return 5'h07;
    return l[2] ? 5'h0e : 5'h00;
  endfunction : exp_lat
  task automatic wcmd;
    for (int k = 0; k < 300 && o_bus_cmd !== 1'b1; k++) @(negedge i_mclk);
  endtask : wcmd
  // first transfer also waits for the bus period to be measured
  task automatic wbus;
    for (int k = 0; k < 600 && o_bus_busy !== 1'b0; k++) @(negedge i_mclk);
    // one more edge so the model has counted the last beat
    @(negedge i_mclk);
  endtask : wbus
  // lets a running prefetch stream finish so commands are not confused
  task automatic quiet;
    int q;
    q = 0;
    for (int k = 0; k < 3000 && q < 60; k++) begin
      @(negedge i_mclk);
      q = o_bus_busy ? 0 : q + 1;
    end
  endtask : quiet
  task automatic done_n(input int n);
    i_miss_done = 1'b1;
    repeat (n) @(negedge i_mclk);
    i_miss_done = 1'b0;
  endtask : done_n
  task automatic acc(input logic [31:0] ad, input logic [2:0] l, input logic f,
    input logic s);
    @(negedge i_mclk);
    for (int k = 0; k < 400 && o_acc_ready !== 1'b1; k++) @(negedge i_mclk);
    {i_acc_valid, i_acc_addr, i_hit_lvl, i_acc_fp, i_acc_sw_pf, i_acc_nt} = {1'b1, ad, l, f, s, s};
    i_acc_set = 4'($urandom);
    i_hit_way = 3'($urandom);
    @(negedge i_mclk);
    i_acc_valid = 1'b0;
    chk(o_acc_lat, exp_lat(l, f));
    if (l[1] || l[2]) chk(o_victim[l[2] ? 2 : 1] != i_hit_way, 1'b1);
  endtask : acc
  task automatic miss(input logic [31:0] ad, input logic s, input logic [2:0] f);
    acc(ad, 3'h0, 1'b0, s);
    wcmd;
    chk(o_bus_addr, ad & 32'hffff_ff80);
    chk({o_bus_wr, o_bus_beats, o_bus_fill}, {1'b0, 5'h10, f});
    wbus;
    chk(n_beats, 5'h10);
  endtask : miss
  initial begin
    {i_rstn, i_ld_alloc, i_ld_dealloc, i_ld_issue, i_ld_spec, i_ld_fault, i_br_resolved,
      i_br_mispredict, i_st_alloc, i_st_exec, i_st_uc, i_st_retire, i_st_wr_ready,
      i_acc_valid, i_acc_sw_pf, i_acc_nt, i_acc_fp, i_miss_done, i_evict_valid} = '0;
    {i_ld_addr, i_st_addr, i_acc_addr, i_evict_addr, i_ld_size, i_st_size, i_acc_set,
      i_st_idx, i_hit_lvl, i_hit_way} = '0;
    void'($urandom(25445));
    repeat (12) @(negedge i_mclk);
    chk({o_init_done, o_bus_busy, o_acc_ready, o_st_wr_valid}, 4'h0);
    i_rstn = 1'b1;
    for (int k = 0; k < 20 && o_init_done !== 1'b1; k++) @(negedge i_mclk);
    chk({o_ld_full, o_st_full, o_st_tail, o_miss_cnt}, 11'h000);
    @(negedge i_mclk);
    for (int i = 0; i < 49; i++) begin
      chk(o_ld_full, i >= 48);
      i_ld_alloc = 1'b1;
      @(negedge i_mclk);
    end
    i_ld_alloc = 1'b0;
    chk(o_ld_full, 1'b1);
    i_ld_dealloc = 1'b1;
    @(negedge i_mclk);
    i_ld_dealloc = 1'b0;
    chk(o_ld_full, 1'b0);
    for (int i = 0; i < 25; i++) begin
      chk(o_st_full, i >= 24);
      if (i < 24) chk(o_st_tail, i);
      i_st_alloc = 1'b1;
      @(negedge i_mclk);
    end
    i_st_alloc = 1'b0;
    // executed youngest first, so drain order shows program order
    {i_st_exec, i_st_size} = {1'b1, 4'h8};
    for (int i = 23; i >= 0; i--) begin
      sq[i] = ($urandom & 32'hffff_f000) | (i << 6) | 32'h8;
      i_st_idx = 5'(i);
      i_st_addr = sq[i];
      @(negedge i_mclk);
    end
    i_st_exec = 1'b0;
    for (int j = 0; j < 3; j++) begin
      i_ld_issue = 1'b1;
      i_ld_addr = (j == 2) ? sq[5] + 32'h4 : sq[5];
      i_ld_size = (j == 1) ? 4'h9 : 4'h8;
      @(negedge i_mclk);
      i_ld_issue = 1'b0;
      chk(o_fwd_hit, j == 0);
      if (j == 0) chk(o_fwd_idx, 5'h05);
      @(negedge i_mclk);
    end
    i_st_retire = 1'b1;
    repeat (24) @(negedge i_mclk);
    i_st_retire = 1'b0;
    for (int i = 0; i < 24; i++) begin
      for (int k = 0; k < 50 && o_st_wr_valid !== 1'b1; k++) @(negedge i_mclk);
      chk(o_st_wr_addr, sq[i]);
      i_st_wr_ready = 1'b1;
      @(negedge i_mclk);
      i_st_wr_ready = 1'b0;
      @(negedge i_mclk);
    end
    chk(o_st_full, 1'b0);
    for (int j = 0; j < 3; j++) begin
      {i_ld_issue, i_ld_fault, i_ld_spec} = {2'b11, j < 2};
      @(negedge i_mclk);
      {i_ld_issue, i_ld_fault} = 2'b00;
      chk(o_page_fault, j == 2);
      @(negedge i_mclk);
      chk(o_page_fault, 1'b0);
      {i_br_resolved, i_br_mispredict} = {1'b1, j == 1};
      @(negedge i_mclk);
      {i_br_resolved, i_br_mispredict} = 2'b00;
      chk(o_page_fault, j == 0);
    end
    acc(32'h100, 3'h1, 1'b0, 1'b0);
    acc(32'h140, 3'h1, 1'b1, 1'b0);
    acc(32'h180, 3'h2, 1'b0, 1'b0);
    acc(32'h1c0, 3'h4, 1'b1, 1'b0);
    chk(o_miss_cnt, 4'h2);
    done_n(2);
    for (int i = 0; i < 4; i++) acc(32'h200 + i * 64, 3'h2, 1'b0, 1'b0);
    chk({o_miss_cnt, o_acc_ready}, 5'h08);
    done_n(4);
    chk(o_miss_cnt, 4'h0);
    miss(32'h7000_0040, 1'b1, 3'h1);
    {i_evict_valid, i_evict_addr} = {1'b1, 32'h4440};
    for (int k = 0; k < 50 && o_evict_ready !== 1'b1; k++) @(negedge i_mclk);
    @(negedge i_mclk);
    i_evict_valid = 1'b0;
    wcmd;
    chk({o_bus_wr, o_bus_beats}, 6'h28);
    chk(o_bus_addr, 32'h4440);
    wbus;
    chk(n_beats, 5'h08);
    // uncached store leaves as a single-beat bus write
    i_st_alloc = 1'b1;
    @(negedge i_mclk);
    {i_st_alloc, i_st_exec, i_st_uc, i_st_idx, i_st_addr} = {3'b011, 5'h00, 32'h9008};
    @(negedge i_mclk);
    {i_st_exec, i_st_retire} = 2'b01;
    @(negedge i_mclk);
    i_st_retire = 1'b0;
    wcmd;
    chk({o_bus_wr, o_bus_uc, o_bus_beats}, 7'h61);
    chk(o_bus_addr, 32'h9008);
    wbus;
    chk(n_beats, 5'h01);
    // page edge, too far apart, then an upward and a downward stream
    for (int j = 0; j < 4; j++) begin
      quiet;
      pg = ($urandom & 32'hff00_0000) | (j << 20);
      a = pg | po[j];
      miss(a, 1'b0, 3'h7);
      miss(a + ps[j], 1'b0, 3'h7);
      wcmd;
      chk(o_bus_cmd, j > 1);
      if (j > 1) chk(o_bus_addr, a + ps[j] + ps[j]);
      if (j > 1) chk(o_bus_fill, 3'h2);
    end
    close_out;
  end
endmodule : cms_top_bench

// [verilog/cms_pkg.sv]
package cms_pkg;
  localparam int ADDR_W = 32;
  localparam int LINE_SH = 6;
  localparam int SECTOR_SH = 7;
  localparam int PAGE_SH = 12;
  localparam logic [4:0] RD_BEATS = 5'h10;
  localparam logic [4:0] WB_BEATS = 5'h08;
  localparam logic [4:0] UC_BEATS = 5'h01;
  localparam logic [1:0] BEATS_LAST = 2'h3;
  localparam int LD_ENTRIES = 48;
  localparam int ST_ENTRIES = 24;
  localparam int MISS_BASE = 4;
  localparam int MISS_ENH = 8;
  localparam int THR_BIG = 512;
  localparam int THR_SMALL = 256;
  localparam int L1_WAYS_SMALL = 4;
  localparam int L1_WAYS_BIG = 8;
  localparam int LX_WAYS = 8;
  localparam logic [4:0] LAT_L1S_INT = 5'h02;
  localparam logic [4:0] LAT_L1S_FP = 5'h09;
  localparam logic [4:0] LAT_L1B_INT = 5'h04;
  localparam logic [4:0] LAT_L1B_FP = 5'h0c;
  localparam logic [4:0] LAT_L2_SMALL = 5'h07;
  localparam logic [4:0] LAT_L2_1M = 5'h12;
  localparam logic [4:0] LAT_L2_2M = 5'h14;
  localparam logic [4:0] LAT_L3 = 5'h0e;
  localparam logic [2:0] FILL_L1 = 3'h1;
  localparam logic [2:0] FILL_L2 = 3'h2;
  localparam logic [2:0] FILL_ALL = 3'h7;
  localparam logic [1:0] L2CFG_SMALL = 2'h0;
  localparam logic [1:0] L2CFG_1M = 2'h1;
  localparam logic [1:0] L2CFG_2M = 2'h2;
  typedef enum logic [1:0] {CMS_IDLE = 2'b01, CMS_XFER = 2'b10} cms_bus_e;
endpackage : cms_pkg

// [verilog/cms_top.sv]
// What this block does
// - first level splits data cache from decoded_instr_line_cache; deeper levels unified
// - levels are non-inclusive; no back-invalidation of inner levels
// - every level picks victims by tree pseudo-LRU kept per set
// - level-one data: 64-byte lines, write-through; 8KB/4-way 2/9 or 16KB/8-way 4/12
// - level two: 8-way, 64-byte, write-back; latency 7, 18 or 20
// - optional level three: 8-way, write-back, 64-byte, latency 14
// - read miss fetches a two-line sector; a cacheable write moves one line
// - only a miss in the outermost level starts a demand bus read
// - cacheable write 64 bytes, uncached write 8-byte pieces, read two lines
// - bus clock sampled; four data beats per bus clock period
// - hardware prefetcher fills level two, several streams, up or down
// - stream starts after two last-level misses within threshold distance
// - prefetch requests never cross a 4-KByte page
// - software prefetch is a hint using miss resources; non-temporal fills level one only
// - at most one load and one store taken per clock
// - admission needs a free entry: 48 load and 24 store entries
// - speculative load faults are held until the path resolves
// - loads proceed out of order versus loads and other-address stores
// - stores leave the buffer strictly in program order
// - inner-level misses do not block later loads, a last-level miss holds off access until its bus read ends; four or eight outstanding
// - buffered stores drain later, yielding bus to demand traffic
// - trigger threshold is 512 bytes large config, 256 small
// - forward only from executed older store, same address, subset, not line-crossing
`timescale 1ns/1ns
module cms_plru #(
  parameter int WAYS = 8,
  parameter int SETS = 16
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // touch and victim
  input wire logic i_touch,
  input wire logic [$clog2(SETS)-1:0] i_set,
  input wire logic [2:0] i_way,
  output logic [2:0] o_victim
);
  localparam int LW = $clog2(WAYS);
  typedef struct packed {
    logic [SETS-1:0][WAYS-1:0] tree;
    logic [2:0] vic;
  } cms_plru_s;
  cms_plru_s s_ff;
  cms_plru_s nxt_s;

  always_comb begin
    int node;
    int v;
    node = 1;
    v = 0;
    nxt_s = s_ff;
    // point each node on the path away from the touched way
    for (int lv = 0; lv < LW; lv++) begin
      if (i_touch) begin
        nxt_s.tree[i_set][node] = ~i_way[LW-1-lv];
      end
      node = 2 * node + int'(i_way[LW-1-lv]);
    end
    node = 1;
    for (int lv = 0; lv < LW; lv++) begin
      v = 2 * v + int'(nxt_s.tree[i_set][node]);
      node = 2 * node + int'(nxt_s.tree[i_set][node]);
    end
    nxt_s.vic = 3'(v);
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end
  assign o_victim = s_ff.vic;
endmodule : cms_plru

module cms_top #(
  parameter bit BIG_CFG = 1'b0,
  parameter bit ENH_MISS = 1'b0,
  parameter bit L3_PRESENT = 1'b1,
  parameter logic [1:0] L2_CFG = cms_pkg::L2CFG_SMALL,
  parameter int SETS = 16,
  parameter int NSTREAM = 4,
  parameter int AW = cms_pkg::ADDR_W
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // load buffer
  input wire logic i_ld_alloc,
  input wire logic i_ld_dealloc,
  output logic o_ld_full,
  input wire logic i_ld_issue,
  input wire logic i_ld_spec,
  input wire logic i_ld_fault,
  input wire logic [AW-1:0] i_ld_addr,
  input wire logic [3:0] i_ld_size,
  output logic o_fwd_hit,
  output logic [4:0] o_fwd_idx,
  // path resolution
  input wire logic i_br_resolved,
  input wire logic i_br_mispredict,
  output logic o_page_fault,
  // store buffer
  input wire logic i_st_alloc,
  output logic o_st_full,
  output logic [4:0] o_st_tail,
  input wire logic i_st_exec,
  input wire logic [4:0] i_st_idx,
  input wire logic [AW-1:0] i_st_addr,
  input wire logic [3:0] i_st_size,
  input wire logic i_st_uc,
  input wire logic i_st_retire,
  output logic o_st_wr_valid,
  output logic [AW-1:0] o_st_wr_addr,
  input wire logic i_st_wr_ready,
  // cache access
  input wire logic i_acc_valid,
  output logic o_acc_ready,
  input wire logic [AW-1:0] i_acc_addr,
  input wire logic i_acc_sw_pf,
  input wire logic i_acc_nt,
  input wire logic i_acc_fp,
  input wire logic [2:0] i_hit_lvl,
  input wire logic [$clog2(SETS)-1:0] i_acc_set,
  input wire logic [2:0] i_hit_way,
  input wire logic i_miss_done,
  output logic [4:0] o_acc_lat,
  output logic [3:0] o_miss_cnt,
  output logic [2:0][2:0] o_victim,
  // eviction
  input wire logic i_evict_valid,
  input wire logic [AW-1:0] i_evict_addr,
  output logic o_evict_ready,
  // system bus
  input wire logic i_bus_clk,
  output logic o_bus_cmd,
  output logic o_bus_wr,
  output logic o_bus_uc,
  output logic [AW-1:0] o_bus_addr,
  output logic [4:0] o_bus_beats,
  output logic o_bus_beat,
  output logic [2:0] o_bus_fill,
  output logic o_bus_busy,
  // status
  output logic o_init_done
);
  localparam int SIW = 5;
  localparam int MAXMISS = ENH_MISS ? cms_pkg::MISS_ENH : cms_pkg::MISS_BASE;
  localparam logic [AW-1:0] THR = AW'(BIG_CFG ? cms_pkg::THR_BIG : cms_pkg::THR_SMALL);
  localparam logic [AW-1:0] SSTEP = AW'(1) << cms_pkg::SECTOR_SH;
  localparam logic [SIW-1:0] ST_LAST = SIW'(cms_pkg::ST_ENTRIES - 1);
  localparam logic [SIW:0] ST_N = (SIW+1)'(cms_pkg::ST_ENTRIES);
  localparam logic [5:0] LD_N = 6'(cms_pkg::LD_ENTRIES);
  localparam int L1W = BIG_CFG ? cms_pkg::L1_WAYS_BIG : cms_pkg::L1_WAYS_SMALL;
  localparam int SN = cms_pkg::ST_ENTRIES;

  typedef struct packed {
    logic init_done;
    logic [2:0] bs;
    logic blvl;
    logic [7:0] pcnt;
    logic [7:0] qtr;
    logic [7:0] qcnt;
    logic [1:0] bn;
    logic beat;
    logic [5:0] ld_cnt;
    logic [SIW-1:0] sh;
    logic [SIW-1:0] st;
    logic [SIW:0] sc;
    logic [SIW:0] rc;
    logic [SN-1:0][AW-1:0] sa;
    logic [SN-1:0][3:0] ssz;
    logic [SN-1:0] sx;
    logic [SN-1:0] su;
    logic fhit;
    logic [SIW-1:0] fidx;
    logic fault;
    logic pfault;
    logic [3:0] mc;
    logic rdp;
    logic [AW-1:0] rda;
    logic [2:0] rdl;
    logic lmv;
    logic [AW-1:0] lma;
    logic [NSTREAM-1:0] pv;
    logic [NSTREAM-1:0] pdn;
    logic [NSTREAM-1:0][AW-1:0] pa;
    cms_pkg::cms_bus_e bst;
    logic cmd;
    logic bwr;
    logic buc;
    logic bdem;
    logic [AW-1:0] ba;
    logic [4:0] blen;
    logic [4:0] bleft;
    logic [2:0] bfill;
    logic bbeat;
    logic [4:0] lat;
  } cms_st_s;

  logic [1:0] rsync_ff;
  logic rst_n;
  cms_st_s s_ff;
  cms_st_s nxt_s;
  logic hrdy;
  logic acc_take;
  logic outer_miss;

  function automatic logic [SIW-1:0] wrap(input logic [SIW-1:0] x);
    return (x == ST_LAST) ? '0 : x + 1'b1;
  endfunction : wrap

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      rsync_ff <= 2'h0;
    end else begin
      rsync_ff <= {rsync_ff[0], 1'b1};
    end
  end
  assign rst_n = rsync_ff[1];

  assign hrdy = (s_ff.sc != '0) && (s_ff.rc != '0) && s_ff.sx[s_ff.sh];
  assign o_acc_ready = s_ff.init_done && !s_ff.rdp && (int'(s_ff.mc) < MAXMISS);
  assign acc_take = i_acc_valid && o_acc_ready;
  // a third-level hit only counts when that level exists
  assign outer_miss = !i_hit_lvl[0] && !i_hit_lvl[1] && (!L3_PRESENT || !i_hit_lvl[2]);
  assign o_evict_ready = s_ff.init_done && (s_ff.bst == cms_pkg::CMS_IDLE) && !s_ff.rdp;
  assign o_st_wr_valid = hrdy && !s_ff.su[s_ff.sh];

  always_comb begin
    logic fh;
    logic [SIW-1:0] fx;
    int fi;
    logic [AW-1:0] d;
    logic [AW-1:0] mag;
    logic [AW-1:0] na;
    logic got;
    logic go;
    logic [4:0] glen;
    logic [AW-1:0] gad;
    logic [2:0] gfl;
    logic pop;
    logic mi;
    logic md;
    fh = 1'b0;
    fx = '0;
    fi = 0;
    d = '0;
    mag = '0;
    na = '0;
    got = 1'b0;
    go = 1'b0;
    glen = '0;
    gad = '0;
    gfl = '0;
    pop = 1'b0;
    mi = 1'b0;
    md = i_miss_done && (s_ff.mc != '0);
    nxt_s = s_ff;
    nxt_s.init_done = 1'b1;
    nxt_s.cmd = 1'b0;
    nxt_s.bbeat = 1'b0;
    nxt_s.beat = 1'b0;
    nxt_s.pfault = 1'b0;
    // bus clock edge finder; a quarter of its period spaces the beats
    nxt_s.bs = {s_ff.bs[1:0], i_bus_clk};
    if (s_ff.bs[1] == s_ff.bs[2]) begin
      nxt_s.blvl = s_ff.bs[2];
    end
    if (!s_ff.blvl && s_ff.bs[1] && s_ff.bs[2]) begin
      nxt_s.qtr = (s_ff.pcnt >> 2) + 8'h01;
      nxt_s.pcnt = 8'h00;
      nxt_s.qcnt = 8'h00;
      nxt_s.bn = 2'h0;
      nxt_s.beat = 1'b1;
    end else begin
      nxt_s.pcnt = (s_ff.pcnt == 8'hff) ? s_ff.pcnt : s_ff.pcnt + 8'h01;
      nxt_s.qcnt = (s_ff.qcnt == 8'hff) ? s_ff.qcnt : s_ff.qcnt + 8'h01;
      if (s_ff.qtr != 8'h00 && s_ff.qcnt + 8'h01 >= s_ff.qtr && s_ff.bn != cms_pkg::BEATS_LAST) begin
        nxt_s.qcnt = 8'h00;
        nxt_s.bn = s_ff.bn + 2'h1;
        nxt_s.beat = 1'b1;
      end
    end
    // load entries: one admitted per clock at most
    nxt_s.ld_cnt = s_ff.ld_cnt + 6'((i_ld_alloc && !o_ld_full && s_ff.init_done) ? 1 : 0)
                   - 6'((i_ld_dealloc && s_ff.ld_cnt != '0) ? 1 : 0);
    // a deferred fault is released only on the correct path; new fault wins
    if (s_ff.fault && i_br_resolved) begin
      nxt_s.fault = 1'b0;
      nxt_s.pfault = !i_br_mispredict;
    end
    if (i_ld_issue && i_ld_fault) begin
      if (i_ld_spec) begin
        nxt_s.fault = 1'b1;
      end else begin
        nxt_s.pfault = 1'b1;
      end
    end
    // youngest matching executed store; all buffered stores are older than the load
    for (int k = 0; k < SN; k++) begin
      fi = (int'(s_ff.sh) + k >= SN) ? int'(s_ff.sh) + k - SN : int'(s_ff.sh) + k;
      if (k < int'(s_ff.sc) && s_ff.sx[fi] && s_ff.sa[fi] == i_ld_addr &&
          i_ld_size <= s_ff.ssz[fi] &&
          ({1'b0, s_ff.sa[fi][5:0]} + {3'b000, s_ff.ssz[fi]} <= 7'h40)) begin
        fh = 1'b1;
        fx = SIW'(fi);
      end
    end
    if (i_ld_issue) begin
      nxt_s.fhit = fh;
      nxt_s.fidx = fx;
    end
    if (i_st_exec) begin
      nxt_s.sa[i_st_idx] = i_st_addr;
      nxt_s.ssz[i_st_idx] = i_st_size;
      nxt_s.su[i_st_idx] = i_st_uc;
      nxt_s.sx[i_st_idx] = 1'b1;
    end
    if (i_st_alloc && !o_st_full && s_ff.init_done) begin
      nxt_s.sx[s_ff.st] = 1'b0;
      nxt_s.st = wrap(s_ff.st);
    end
    // access: hit latency, miss tracking, bus read only past the last level
    if (acc_take) begin
      nxt_s.lat = 5'h00;
      if (i_hit_lvl[0]) begin
        nxt_s.lat = BIG_CFG ? (i_acc_fp ? cms_pkg::LAT_L1B_FP : cms_pkg::LAT_L1B_INT)
                            : (i_acc_fp ? cms_pkg::LAT_L1S_FP : cms_pkg::LAT_L1S_INT);
      end else if (i_hit_lvl[1]) begin
        nxt_s.lat = (L2_CFG == cms_pkg::L2CFG_2M) ? cms_pkg::LAT_L2_2M :
                    (L2_CFG == cms_pkg::L2CFG_1M) ? cms_pkg::LAT_L2_1M : cms_pkg::LAT_L2_SMALL;
      end else if (L3_PRESENT && i_hit_lvl[2]) begin
        nxt_s.lat = cms_pkg::LAT_L3;
      end
      mi = !i_hit_lvl[0];
      if (outer_miss) begin
        nxt_s.rdp = 1'b1;
        nxt_s.rda = {i_acc_addr[AW-1:cms_pkg::SECTOR_SH], {cms_pkg::SECTOR_SH{1'b0}}};
        nxt_s.rdl = i_acc_nt ? cms_pkg::FILL_L1 : cms_pkg::FILL_ALL;
        if (!i_acc_sw_pf) begin
          d = i_acc_addr - s_ff.lma;
          mag = d[AW-1] ? -d : d;
          na = d[AW-1] ? nxt_s.rda - SSTEP : nxt_s.rda + SSTEP;
          if (s_ff.lmv && mag != '0 && mag <= THR &&
              na[AW-1:cms_pkg::PAGE_SH] == i_acc_addr[AW-1:cms_pkg::PAGE_SH]) begin
            for (int p = 0; p < NSTREAM; p++) begin
              if (!got && !s_ff.pv[p]) begin
                got = 1'b1;
                nxt_s.pv[p] = 1'b1;
                nxt_s.pdn[p] = d[AW-1];
                nxt_s.pa[p] = na;
              end
            end
          end
          nxt_s.lmv = 1'b1;
          nxt_s.lma = i_acc_addr;
        end
      end
    end
    // bus engine: demand read, eviction, uncached store, then prefetch
    unique case (s_ff.bst)
      cms_pkg::CMS_IDLE: begin
        if (s_ff.init_done) begin
          if (s_ff.rdp) begin
            go = 1'b1;
            glen = cms_pkg::RD_BEATS;
            gad = s_ff.rda;
            gfl = s_ff.rdl;
            nxt_s.bdem = 1'b1;
            nxt_s.bwr = 1'b0;
            nxt_s.buc = 1'b0;
          end else if (i_evict_valid) begin
            go = 1'b1;
            glen = cms_pkg::WB_BEATS;
            gad = {i_evict_addr[AW-1:cms_pkg::LINE_SH], {cms_pkg::LINE_SH{1'b0}}};
            nxt_s.bdem = 1'b0;
            nxt_s.bwr = 1'b1;
            nxt_s.buc = 1'b0;
          end else if (hrdy && s_ff.su[s_ff.sh]) begin
            go = 1'b1;
            glen = cms_pkg::UC_BEATS;
            gad = s_ff.sa[s_ff.sh];
            pop = 1'b1;
            nxt_s.bdem = 1'b0;
            nxt_s.bwr = 1'b1;
            nxt_s.buc = 1'b1;
          end else begin
            for (int p = 0; p < NSTREAM; p++) begin
              if (!go && s_ff.pv[p]) begin
                go = 1'b1;
                glen = cms_pkg::RD_BEATS;
                gad = s_ff.pa[p];
                gfl = cms_pkg::FILL_L2;
                na = s_ff.pdn[p] ? s_ff.pa[p] - SSTEP : s_ff.pa[p] + SSTEP;
                nxt_s.pa[p] = na;
                // the stream dies at the page edge
                if (na[AW-1:cms_pkg::PAGE_SH] != s_ff.pa[p][AW-1:cms_pkg::PAGE_SH]) begin
                  nxt_s.pv[p] = 1'b0;
                end
              end
            end
            nxt_s.bdem = 1'b0;
            nxt_s.bwr = 1'b0;
            nxt_s.buc = 1'b0;
          end
        end
        if (go) begin
          nxt_s.cmd = 1'b1;
          nxt_s.ba = gad;
          nxt_s.blen = glen;
          nxt_s.bleft = glen;
          nxt_s.bfill = gfl;
          nxt_s.bst = cms_pkg::CMS_XFER;
        end
      end
      cms_pkg::CMS_XFER: begin
        if (s_ff.beat) begin
          nxt_s.bbeat = 1'b1;
          nxt_s.bleft = s_ff.bleft - 5'h01;
          if (s_ff.bleft == 5'h01) begin
            nxt_s.bst = cms_pkg::CMS_IDLE;
            if (s_ff.bdem) begin
              nxt_s.rdp = 1'b0;
              md = s_ff.mc != '0;
            end
          end
        end
      end
    endcase
    // in-order drain: only the head ever leaves
    pop = pop || (o_st_wr_valid && i_st_wr_ready);
    if (pop) begin
      nxt_s.sh = wrap(s_ff.sh);
    end
    nxt_s.sc = s_ff.sc + (SIW+1)'((i_st_alloc && !o_st_full && s_ff.init_done) ? 1 : 0)
               - (SIW+1)'(pop ? 1 : 0);
    nxt_s.rc = s_ff.rc + (SIW+1)'((i_st_retire && s_ff.rc < s_ff.sc) ? 1 : 0)
               - (SIW+1)'(pop ? 1 : 0);
    nxt_s.mc = s_ff.mc + 4'(mi ? 1 : 0) - 4'(md ? 1 : 0);
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '{bst: cms_pkg::CMS_IDLE, default: '0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  // replacement state per level; inner levels never back-invalidated
  for (genvar g = 0; g < 3; g++) begin : g_plru
    cms_plru #(
      .WAYS(g == 0 ? L1W : cms_pkg::LX_WAYS),
      .SETS(SETS)
    ) u_plru (
      .i_clk(i_mclk),
      .i_rst_n(rst_n),
      .i_touch(acc_take && i_hit_lvl[g] && (g != 2 || L3_PRESENT)),
      .i_set(i_acc_set),
      .i_way(i_hit_way),
      .o_victim(o_victim[g])
    );
  end

  assign o_ld_full = s_ff.ld_cnt == LD_N;
  assign o_st_full = s_ff.sc == ST_N;
  assign o_st_tail = s_ff.st;
  assign o_fwd_hit = s_ff.fhit;
  assign o_fwd_idx = s_ff.fidx;
  assign o_page_fault = s_ff.pfault;
  assign o_st_wr_addr = s_ff.sa[s_ff.sh];
  assign o_acc_lat = s_ff.lat;
  assign o_miss_cnt = s_ff.mc;
  assign o_bus_cmd = s_ff.cmd;
  assign o_bus_wr = s_ff.bwr;
  assign o_bus_uc = s_ff.buc;
  assign o_bus_addr = s_ff.ba;
  assign o_bus_beats = s_ff.blen;
  assign o_bus_beat = s_ff.bbeat;
  assign o_bus_fill = s_ff.bfill;
  assign o_bus_busy = s_ff.bst == cms_pkg::CMS_XFER;
  assign o_init_done = s_ff.init_done;

  default clocking @(posedge i_mclk); endclocking
  default disable iff (!rst_n);
  a_ld_cap: assert property ((o_ld_full && i_ld_alloc && !i_ld_dealloc) |=> s_ff.ld_cnt == LD_N)
    else $error("load entries overfilled");
  a_st_inorder: assert property ((o_st_wr_valid && i_st_wr_ready) |=> s_ff.sh == wrap($past(s_ff.sh)))
    else $error("store drain out of order");
  a_rd_sector: assert property ((o_bus_cmd && !o_bus_wr) |-> o_bus_beats == cms_pkg::RD_BEATS && o_bus_addr[6:0] == 7'h00)
    else $error("bus read not a sector");
  a_wr_size: assert property ((o_bus_cmd && o_bus_wr) |-> o_bus_beats == (o_bus_uc ? cms_pkg::UC_BEATS : cms_pkg::WB_BEATS))
    else $error("bus write length wrong");
  a_llc_only: assert property ((acc_take && !outer_miss) |=> !s_ff.rdp)
    else $error("bus read without last-level miss");
  a_miss_cap: assert property (int'(s_ff.mc) <= MAXMISS)
    else $error("too many outstanding misses");
  a_fault_defer: assert property ((s_ff.fault && i_br_resolved && i_br_mispredict && !i_ld_issue) |=> !o_page_fault && !s_ff.fault)
    else $error("fault raised on wrong path");
  a_nt_fill: assert property ((acc_take && outer_miss && i_acc_nt) |=> s_ff.rdl == cms_pkg::FILL_L1 ##[1:4] (o_bus_cmd && o_bus_fill == cms_pkg::FILL_L1))
    else $error("non-temporal fill beyond level one");
  a_init_gate: assert property (!s_ff.init_done |-> !o_acc_ready && !o_bus_cmd && !o_st_wr_valid)
    else $error("operation before init");
  c_sector_rd: cover property (o_bus_cmd && !o_bus_wr && o_bus_fill == cms_pkg::FILL_ALL);
  c_pf_rd: cover property (o_bus_cmd && o_bus_fill == cms_pkg::FILL_L2);
  c_uc_wr: cover property (o_bus_cmd && o_bus_uc);
  c_fwd: cover property (o_fwd_hit);
endmodule : cms_top
